// >>> hw/tsp_pkg.sv
// constants and carrier types for the single pulse / capture timer
// assumes a 50 MHz system clock and an AXI4-Lite master with 8-bit addresses
package tsp_pkg;
	// -----------------------------------------------------------------
	// sizes
	// -----------------------------------------------------------------
	localparam int CNT_W   = 10;
	localparam int PER_W   = 3;
	localparam int PER_SH  = 7;
	localparam int CTRL_W  = 16;
	localparam int ADDR_W  = 8;
	localparam int NPIN    = 5;
	localparam int PIN_A   = 0;
	localparam int PIN_B0  = 1;
	localparam int PIN_TRG = 4;
	localparam int FLAG_A  = 0;
	localparam int FLAG_B  = 1;
	localparam int FLAG_P  = 2;

	// -----------------------------------------------------------------
	// register map, byte addresses
	// -----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CMPA = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CMPB = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CMPP = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_CNT  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h14;

	// -----------------------------------------------------------------
	// encodings
	// -----------------------------------------------------------------
	localparam logic [1:0] MODE_SP   = 2'h2;
	localparam logic [1:0] MODE_CAP  = 2'h1;
	localparam logic [1:0] FUNC_SP   = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam logic [1:0] EDGE_NONE = 2'h3;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_ERR  = 2'h2;

	typedef struct packed {
		logic       counter_run;
		logic [1:0] chan_b_pin_sel;
		logic       chan_b_out_polarity;
		logic       chan_a_out_polarity;
		logic       chan_b_out_state;
		logic       chan_a_out_state;
		logic       counter_clear_select;
		logic       chan_b_pin_func_hi;
		logic       chan_b_pin_func_lo;
		logic       chan_a_pin_func_hi;
		logic       chan_a_pin_func_lo;
		logic       chan_b_mode_sel_hi;
		logic       chan_b_mode_sel_lo;
		logic       chan_a_mode_sel_hi;
		logic       chan_a_mode_sel_lo;
	} tsp_ctrl_t;

	localparam tsp_ctrl_t CTRL_RST = 16'h0000;

	typedef struct packed {
		logic [2:0] b;
		logic       a;
	} tsp_pins_t;
endpackage

// >>> hw/tsp_timer.sv
// single pulse output and input capture timer with AXI4-Lite registers
// assumes pins are asynchronous to clk; one clock domain, no interrupt logic
//
// Notes on behaviour
// [R1] software enters single pulse with modes 10 and pin functions 11
// [R2] run bit rising starts counter and raises channel A pulse
// [R3] compare B match raises channel B pulse
// [R4] trigger pin rising edge sets run bit in single pulse mode
// [R5] software clearing run ends both pulses
// [R6] compare A match clears run, stops counter, ends both pulses
// [R7] A width equals compare A, B width equals A minus B
// [R8] compare A and B matches raise flags in single pulse mode
// [R9] counter zeroed only on run rise; period and clear select unused
// [R10] software enters capture mode with both modes 01
// [R11] pin function selects rising, falling, both or no capture
// [R12] capture counter starts on run rise, free runs until run falls
// [R13] pin edge copies counter into compare A or B and raises flag
// [R14] period match zeroes counter and raises period flag
// [R15] period value zero lets counter use full range
// [R16] pin transitions capture even while pin is driven as output
// [R17] capture mode ignores clear, state, polarity bits; drives no output
// [R18] channel B captures from one of three selectable pins
// [R19] pins are synchronised; each edge gives exactly one event
// [R20] channel B pulse drives only the selected channel B pin
`timescale 1ns/1ps
module tsp_timer (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic [tsp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [tsp_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      ext_trigger_clock_pin,
	input  wire logic                      chan_a_pin_in,
	output logic                           chan_a_pin_out,
	output logic                           chan_a_pin_oe,
	input  wire logic [2:0]                chan_b_pin_in,
	output logic [2:0]                     chan_b_pin_out,
	output logic [2:0]                     chan_b_pin_oe
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	tsp_pkg::tsp_ctrl_t           ctrl_reg, ctrl_next;
	logic [tsp_pkg::CNT_W-1:0]    cnt_reg, cnt_next;
	logic [tsp_pkg::CNT_W-1:0]    cmpa_reg, cmpa_next;
	logic [tsp_pkg::CNT_W-1:0]    cmpb_reg, cmpb_next;
	logic [tsp_pkg::PER_W-1:0]    cmpp_reg, cmpp_next;
	logic [2:0]                   flag_reg, flag_next;
	logic                         run_prev_reg, run_prev_next;
	logic [1:0]                   pulse_reg, pulse_next;
	tsp_pkg::tsp_pins_t           pout_reg, pout_next;
	tsp_pkg::tsp_pins_t           poe_reg, poe_next;
	logic [tsp_pkg::NPIN-1:0]     s1_reg, s2_reg, s3_reg;
	logic [tsp_pkg::NPIN-1:0]     lvl_reg, lvl_next;
	logic                         awf_reg, awf_next, wf_reg, wf_next;
	logic [tsp_pkg::ADDR_W-1:0]   awa_reg, awa_next;
	logic [31:0]                  wd_reg, wd_next;
	logic [3:0]                   ws_reg, ws_next;
	logic                         bv_reg, bv_next, rv_reg, rv_next;
	logic [1:0]                   br_reg, br_next, rr_reg, rr_next;
	logic [31:0]                  rd_reg, rd_next;

	logic [tsp_pkg::NPIN-1:0]     rise_v, fall_v;
	logic                         sp, cap, rise, counting, do_wr;
	logic                         hit_a, hit_b;
	logic [tsp_pkg::CNT_W-1:0]    inc, period;
	logic [31:0]                  wmask, wmerge;

	// -----------------------------------------------------------------
	// decoders
	// -----------------------------------------------------------------
	function automatic logic [2:0] b_onehot(input logic [1:0] sel);
		b_onehot = (sel == 2'h3) ? 3'h0 : 3'(3'h1 << sel);
	endfunction

	function automatic logic edge_hit(input logic [1:0] f,
		input logic r, input logic fl);
		edge_hit = (f == tsp_pkg::EDGE_RISE) ? r :
			(f == tsp_pkg::EDGE_FALL) ? fl :
			(f == tsp_pkg::EDGE_BOTH) ? (r | fl) : 1'b0;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == tsp_pkg::OFF_CTRL) || (a == tsp_pkg::OFF_CMPA) ||
			(a == tsp_pkg::OFF_CMPB) || (a == tsp_pkg::OFF_CMPP) ||
			(a == tsp_pkg::OFF_CNT) || (a == tsp_pkg::OFF_FLAG);
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		if (a == tsp_pkg::OFF_CTRL) begin
			rd_word = 32'(ctrl_reg);
		end else if (a == tsp_pkg::OFF_CMPA) begin
			rd_word = 32'(cmpa_reg);
		end else if (a == tsp_pkg::OFF_CMPB) begin
			rd_word = 32'(cmpb_reg);
		end else if (a == tsp_pkg::OFF_CMPP) begin
			rd_word = 32'(cmpp_reg);
		end else if (a == tsp_pkg::OFF_CNT) begin
			rd_word = 32'(cnt_reg);
		end else if (a == tsp_pkg::OFF_FLAG) begin
			rd_word = 32'(flag_reg);
		end else begin
			rd_word = 32'h0000_0000;
		end
	endfunction

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	// a level counts once the 2nd and 3rd stages agree; input is read
	// even while the pin drives, so own output edges also capture
	always_comb begin
		lvl_next = (~(s2_reg ^ s3_reg) & s3_reg) |
			((s2_reg ^ s3_reg) & lvl_reg); // R19
		rise_v = lvl_next & ~lvl_reg; // R16
		fall_v = ~lvl_next & lvl_reg;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg  <= {ext_trigger_clock_pin, chan_b_pin_in, chan_a_pin_in};
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	// -----------------------------------------------------------------
	// bus slave
	// -----------------------------------------------------------------
	assign s_axi_awready = ~awf_reg;
	assign s_axi_wready  = ~wf_reg;
	assign s_axi_bvalid  = bv_reg;
	assign s_axi_bresp   = br_reg;
	assign s_axi_arready = ~rv_reg;
	assign s_axi_rvalid  = rv_reg;
	assign s_axi_rresp   = rr_reg;
	assign s_axi_rdata   = rd_reg;
	assign do_wr = awf_reg & wf_reg & ~bv_reg;

	always_comb begin
		awf_next = awf_reg;
		awa_next = awa_reg;
		wf_next  = wf_reg;
		wd_next  = wd_reg;
		ws_next  = ws_reg;
		bv_next  = bv_reg;
		br_next  = br_reg;
		rv_next  = rv_reg;
		rr_next  = rr_reg;
		rd_next  = rd_reg;
		if (s_axi_awvalid & ~awf_reg) begin
			awf_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid & ~wf_reg) begin
			wf_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (bv_reg & s_axi_bready) begin
			bv_next = 1'b0;
		end
		if (do_wr) begin
			awf_next = 1'b0;
			wf_next  = 1'b0;
			bv_next  = 1'b1;
			br_next  = addr_ok(awa_reg) ? tsp_pkg::RESP_OK : tsp_pkg::RESP_ERR;
		end
		if (rv_reg & s_axi_rready) begin
			rv_next = 1'b0;
		end
		if (s_axi_arvalid & ~rv_reg) begin
			rv_next = 1'b1;
			rd_next = rd_word(s_axi_araddr);
			rr_next = addr_ok(s_axi_araddr) ? tsp_pkg::RESP_OK :
				tsp_pkg::RESP_ERR;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awf_reg <= 1'b0;
			awa_reg <= 8'h00;
			wf_reg  <= 1'b0;
			wd_reg  <= 32'h0000_0000;
			ws_reg  <= 4'h0;
			bv_reg  <= 1'b0;
			br_reg  <= 2'h0;
			rv_reg  <= 1'b0;
			rr_reg  <= 2'h0;
			rd_reg  <= 32'h0000_0000;
		end else begin
			awf_reg <= awf_next;
			awa_reg <= awa_next;
			wf_reg  <= wf_next;
			wd_reg  <= wd_next;
			ws_reg  <= ws_next;
			bv_reg  <= bv_next;
			br_reg  <= br_next;
			rv_reg  <= rv_next;
			rr_reg  <= rr_next;
			rd_reg  <= rd_next;
		end
	end

	// -----------------------------------------------------------------
	// timer core
	// -----------------------------------------------------------------
	always_comb begin
		wmask  = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}},
			{8{ws_reg[0]}}};
		wmerge = (rd_word(awa_reg) & ~wmask) | (wd_reg & wmask);
		sp = {ctrl_reg.chan_a_mode_sel_hi, ctrl_reg.chan_a_mode_sel_lo,
			ctrl_reg.chan_b_mode_sel_hi, ctrl_reg.chan_b_mode_sel_lo,
			ctrl_reg.chan_a_pin_func_hi, ctrl_reg.chan_a_pin_func_lo,
			ctrl_reg.chan_b_pin_func_hi, ctrl_reg.chan_b_pin_func_lo} ==
			{tsp_pkg::MODE_SP, tsp_pkg::MODE_SP, tsp_pkg::FUNC_SP,
			tsp_pkg::FUNC_SP}; // R1
		cap = {ctrl_reg.chan_a_mode_sel_hi, ctrl_reg.chan_a_mode_sel_lo,
			ctrl_reg.chan_b_mode_sel_hi, ctrl_reg.chan_b_mode_sel_lo} ==
			{tsp_pkg::MODE_CAP, tsp_pkg::MODE_CAP}; // R10
		rise     = ctrl_reg.counter_run & ~run_prev_reg;
		counting = ctrl_reg.counter_run & ~run_prev_reg ? 1'b0 :
			ctrl_reg.counter_run;
		inc      = cnt_reg + 10'h001;
		period   = {cmpp_reg, {tsp_pkg::PER_SH{1'b0}}};
		hit_a = edge_hit({ctrl_reg.chan_a_pin_func_hi,
			ctrl_reg.chan_a_pin_func_lo}, rise_v[tsp_pkg::PIN_A],
			fall_v[tsp_pkg::PIN_A]); // R11
		hit_b = edge_hit({ctrl_reg.chan_b_pin_func_hi,
			ctrl_reg.chan_b_pin_func_lo},
			|(rise_v[3:1] & b_onehot(ctrl_reg.chan_b_pin_sel)),
			|(fall_v[3:1] & b_onehot(ctrl_reg.chan_b_pin_sel))); // R18
		ctrl_next     = ctrl_reg;
		cmpa_next     = cmpa_reg;
		cmpb_next     = cmpb_reg;
		cmpp_next     = cmpp_reg;
		flag_next     = flag_reg;
		cnt_next      = cnt_reg;
		pulse_next    = pulse_reg;
		run_prev_next = ctrl_reg.counter_run;
		if (do_wr) begin
			if (awa_reg == tsp_pkg::OFF_CTRL) begin
				ctrl_next = tsp_pkg::tsp_ctrl_t'(wmerge[15:0]);
			end else if (awa_reg == tsp_pkg::OFF_CMPA) begin
				cmpa_next = wmerge[9:0];
			end else if (awa_reg == tsp_pkg::OFF_CMPB) begin
				cmpb_next = wmerge[9:0];
			end else if (awa_reg == tsp_pkg::OFF_CMPP) begin
				cmpp_next = wmerge[2:0];
			end else if (awa_reg == tsp_pkg::OFF_FLAG) begin
				// write one to clear; hardware sets below win
				flag_next = flag_reg & ~(wd_reg[2:0] & wmask[2:0]);
			end
		end
		if (sp) begin
			if (rise_v[tsp_pkg::PIN_TRG]) begin
				ctrl_next.counter_run = 1'b1; // R4
			end
			if (rise) begin
				cnt_next   = '0; // R9
				pulse_next = 2'b01; // R2
			end else if (counting) begin
				cnt_next = inc;
				if (inc == cmpb_reg) begin
					pulse_next[1] = 1'b1; // R3
					flag_next[tsp_pkg::FLAG_B] = 1'b1; // R8
				end
				// match on the value being entered gives width = value
				if (inc == cmpa_reg) begin
					ctrl_next.counter_run = 1'b0; // R6
					pulse_next = 2'b00; // R7
					flag_next[tsp_pkg::FLAG_A] = 1'b1; // R8
				end
			end else begin
				pulse_next = 2'b00; // R5
			end
		end else begin
			pulse_next = 2'b00; // R17
			if (cap) begin
				if (rise) begin
					cnt_next = '0; // R12
				end else if (counting) begin
					if (cmpp_reg != 3'h0 && cnt_reg == period) begin
						cnt_next = '0; // R14
						flag_next[tsp_pkg::FLAG_P] = 1'b1;
					end else begin
						cnt_next = inc; // R15
					end
				end
				if (hit_a) begin
					cmpa_next = cnt_reg; // R13
					flag_next[tsp_pkg::FLAG_A] = 1'b1;
				end
				if (hit_b) begin
					cmpb_next = cnt_reg; // R13
					flag_next[tsp_pkg::FLAG_B] = 1'b1;
				end
			end
		end
		pout_next.a = pulse_next[0];
		pout_next.b = {3{pulse_next[1]}} &
			b_onehot(ctrl_next.chan_b_pin_sel); // R20
		poe_next.a  = sp;
		poe_next.b  = sp ? b_onehot(ctrl_reg.chan_b_pin_sel) : 3'h0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg     <= tsp_pkg::CTRL_RST;
			cnt_reg      <= '0;
			cmpa_reg     <= '0;
			cmpb_reg     <= '0;
			cmpp_reg     <= '0;
			flag_reg     <= 3'h0;
			run_prev_reg <= 1'b0;
			pulse_reg    <= 2'h0;
			pout_reg     <= '0;
			poe_reg      <= '0;
		end else begin
			ctrl_reg     <= ctrl_next;
			cnt_reg      <= cnt_next;
			cmpa_reg     <= cmpa_next;
			cmpb_reg     <= cmpb_next;
			cmpp_reg     <= cmpp_next;
			flag_reg     <= flag_next;
			run_prev_reg <= run_prev_next;
			pulse_reg    <= pulse_next;
			pout_reg     <= pout_next;
			poe_reg      <= poe_next;
		end
	end

	assign chan_a_pin_out = pout_reg.a;
	assign chan_a_pin_oe  = poe_reg.a;
	assign chan_b_pin_out = pout_reg.b;
	assign chan_b_pin_oe  = poe_reg.b;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_start_a;
		sp && rise && !do_wr |=> pulse_reg == 2'b01 && cnt_reg == '0;
	endproperty
	a_start_a: assert property (p_start_a) // R2
		else $error("run rise did not start pulse A");
	property p_lead_b;
		sp && counting && inc == cmpb_reg && inc != cmpa_reg && !do_wr
			|=> pulse_reg[1] && flag_reg[tsp_pkg::FLAG_B];
	endproperty
	a_lead_b: assert property (p_lead_b) // R3
		else $error("compare B match missed");
	property p_trig;
		sp && rise_v[tsp_pkg::PIN_TRG] && !(counting && inc == cmpa_reg)
			&& !do_wr |=> ctrl_reg.counter_run;
	endproperty
	a_trig: assert property (p_trig) // R4
		else $error("trigger did not set run");
	property p_sw_stop;
		sp && !ctrl_reg.counter_run |=> pulse_reg == 2'b00;
	endproperty
	a_sw_stop: assert property (p_sw_stop) // R5
		else $error("pulse survived run clear");
	property p_match_a;
		sp && counting && inc == cmpa_reg && !do_wr |=>
			!ctrl_reg.counter_run && pulse_reg == 2'b00 &&
			flag_reg[tsp_pkg::FLAG_A] ##1 $stable(cnt_reg);
	endproperty
	a_match_a: assert property (p_match_a) // R6
		else $error("compare A match did not stop");
	// B lead at compare B and the stop at compare A give width A - B
	property p_width_b;
		sp && $rose(pulse_reg[1]) && !$past(do_wr)
			|-> cnt_reg == cmpb_reg;
	endproperty
	a_width_b: assert property (p_width_b) // R7
		else $error("pulse B lead edge off compare B");
	property p_cap_a;
		cap && hit_a |=> cmpa_reg == $past(cnt_reg) &&
			flag_reg[tsp_pkg::FLAG_A];
	endproperty
	a_cap_a: assert property (p_cap_a) // R13
		else $error("capture A missed");
	property p_period;
		cap && counting && cmpp_reg != 3'h0 && cnt_reg == period
			|=> cnt_reg == '0 && flag_reg[tsp_pkg::FLAG_P];
	endproperty
	a_period: assert property (p_period) // R14
		else $error("period match did not wrap");
	property p_no_cap;
		cap && {ctrl_reg.chan_a_pin_func_hi, ctrl_reg.chan_a_pin_func_lo}
			== tsp_pkg::EDGE_NONE && !do_wr |=> $stable(cmpa_reg);
	endproperty
	a_no_cap: assert property (p_no_cap) // R11
		else $error("capture with edges disabled");
	property p_cap_quiet;
		cap |=> poe_reg == '0 ##1 poe_reg == '0 || !cap;
	endproperty
	a_cap_quiet: assert property (p_cap_quiet) // R17
		else $error("output driven in capture");

	c_pulse:  cover property (sp && counting && inc == cmpa_reg);
	c_trig:   cover property (sp && rise_v[tsp_pkg::PIN_TRG]);
	c_cap_b:  cover property (cap && hit_b);
	c_period: cover property (cap && cnt_reg == period && cmpp_reg != 3'h0);
endmodule

// >>> dv/tsp_pin_model.sv
// far-side pin model: trigger source and capture inputs of the timer
// assumes the bench calls its tasks from one process, just after clk edges
`timescale 1ns/1ps
module tsp_pin_model (
	input  wire logic       clk,
	input  wire logic       chan_a_pin_out,
	input  wire logic       chan_a_pin_oe,
	input  wire logic [2:0] chan_b_pin_out,
	input  wire logic [2:0] chan_b_pin_oe,
	output logic            ext_trigger_clock_pin,
	output wire logic       chan_a_pin_in,
	output wire logic [2:0] chan_b_pin_in
);
	logic       a_drv;
	logic [2:0] b_drv;

	initial begin
		ext_trigger_clock_pin = 1'b0;
		a_drv = 1'b0;
		b_drv = 3'h0;
	end

	// -----------------------------------------------------------------
	// wire level
	// -----------------------------------------------------------------
	// a driven pin loops back, so its own transitions reach the capture
	assign chan_a_pin_in = chan_a_pin_oe ? chan_a_pin_out : a_drv;
	assign chan_b_pin_in = (chan_b_pin_oe & chan_b_pin_out) |
		(~chan_b_pin_oe & b_drv);

	// -----------------------------------------------------------------
	// stimulus
	// -----------------------------------------------------------------
	// long hold: a level that outlives the pulse must not retrigger
	task automatic trigger(input int hold);
		@(posedge clk) ext_trigger_clock_pin <= 1'b1;
		repeat (hold) @(posedge clk);
		ext_trigger_clock_pin <= 1'b0;
	endtask

	task automatic set_a(input logic v);
		@(posedge clk) a_drv <= v;
	endtask

	task automatic set_b(input int k, input logic v);
		@(posedge clk) b_drv[k] <= v;
	endtask
endmodule

// >>> dv/test_timer_single_pulse_and_capture.sv
// self-checking bench for the single pulse / capture timer
// assumes tsp_pkg, tsp_timer and tsp_pin_model are compiled first
`timescale 1ns/1ps
module test_timer_single_pulse_and_capture;
	logic        clk, rst;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, v, va;
	logic [1:0]  bresp, rresp, resp;
	logic        trg, a_in, a_out, a_oe;
	logic [2:0]  b_in, b_out, b_oe;
	int          fail_count, n_tests, a_cnt;
	int          b_cnt[3];

	tsp_timer u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_trigger_clock_pin(trg),
		.chan_a_pin_in(a_in), .chan_a_pin_out(a_out), .chan_a_pin_oe(a_oe),
		.chan_b_pin_in(b_in), .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe));

	tsp_pin_model u_pins (.clk(clk), .chan_a_pin_out(a_out),
		.chan_a_pin_oe(a_oe), .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe),
		.ext_trigger_clock_pin(trg), .chan_a_pin_in(a_in),
		.chan_b_pin_in(b_in));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// pulse widths counted in clocks while the outputs stand high
	always @(posedge clk) begin
		if (a_out === 1'b1) a_cnt++;
		for (int k = 0; k < 3; k++) if (b_out[k] === 1'b1) b_cnt[k]++;
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (i == 50) check("write wait", 0, 1);
	endtask

	task automatic rd(input logic [7:0] a);
		int i;
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		v = rdata; resp = rresp;
		rready <= 1'b0;
		if (i == 50) check("read wait", 0, 1);
	endtask

	// x sets bits that both modes must ignore
	function automatic logic [31:0] ctl(logic [1:0] m, logic [1:0] fa,
		logic [1:0] fb, logic [1:0] bs, logic run, logic x);
		tsp_pkg::tsp_ctrl_t c;
		c = tsp_pkg::CTRL_RST;
		{c.chan_a_mode_sel_hi, c.chan_a_mode_sel_lo} = m;
		{c.chan_b_mode_sel_hi, c.chan_b_mode_sel_lo} = m;
		{c.chan_a_pin_func_hi, c.chan_a_pin_func_lo} = fa;
		{c.chan_b_pin_func_hi, c.chan_b_pin_func_lo} = fb;
		c.chan_b_pin_sel = bs;
		c.counter_run = run;
		c.counter_clear_select = x;
		c.chan_a_out_state = x;
		c.chan_b_out_polarity = x;
		return {16'h0000, c};
	endfunction

	task automatic prep_sp(int ca, int cb);
		wr(tsp_pkg::OFF_CMPA, ca);
		wr(tsp_pkg::OFF_CMPB, cb);
		wr(tsp_pkg::OFF_FLAG, 32'h0000_0007);
		a_cnt = 0;
		b_cnt = '{0, 0, 0};
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_regs();
		rd(tsp_pkg::OFF_CTRL);
		check("ctrl after reset", v, 0);
		check("mapped read resp", resp, tsp_pkg::RESP_OK);
		rd(8'h20);
		check("unmapped read resp", resp, tsp_pkg::RESP_ERR);
		wr(8'h20, 32'h0000_ffff);
		check("unmapped write resp", resp, tsp_pkg::RESP_ERR);
		$display("done regs");
	endtask

	// period 128 and clear select set: a 200 clock pulse must not wrap
	task automatic t_sp_sw();
		wr(tsp_pkg::OFF_CMPP, 1);
		prep_sp(200, 50);
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_SP, tsp_pkg::FUNC_SP,
			tsp_pkg::FUNC_SP, 0, 1, 1));
		repeat (260) @(posedge clk);
		check("pulse a width", a_cnt, 200);
		check("pulse b width", b_cnt[0], 150);
		check("unselected b pin", b_cnt[1] + b_cnt[2], 0);
		rd(tsp_pkg::OFF_CTRL);
		check("run after match", v[15], 0);
		rd(tsp_pkg::OFF_CNT);
		check("stopped counter", v, 200);
		rd(tsp_pkg::OFF_FLAG);
		check("match flags", v, 3);
		$display("done single pulse software");
	endtask

	task automatic t_sp_trig();
		prep_sp(40, 10);
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_SP, tsp_pkg::FUNC_SP,
			tsp_pkg::FUNC_SP, 2, 0, 0));
		u_pins.trigger(60);
		repeat (60) @(posedge clk);
		check("trigger pulse a", a_cnt, 40);
		check("trigger pulse b", b_cnt[2], 30);
		check("b pin 0 idle", b_cnt[0], 0);
		check("sp drive", {a_oe, b_oe}, 4'hc);
		rd(tsp_pkg::OFF_CTRL);
		check("run after trigger", v[15], 0);
		$display("done single pulse trigger");
	endtask

	task automatic t_sp_stop();
		prep_sp(300, 100);
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_SP, tsp_pkg::FUNC_SP,
			tsp_pkg::FUNC_SP, 0, 1, 0));
		repeat (150) @(posedge clk);
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_SP, tsp_pkg::FUNC_SP,
			tsp_pkg::FUNC_SP, 0, 0, 0));
		repeat (4) @(posedge clk);
		check("outputs after stop", {a_out, b_out}, 0);
		check("cut pulse short", 32'(a_cnt < 300 && b_cnt[0] > 0), 1);
		rd(tsp_pkg::OFF_FLAG);
		check("no a match", v, 2);
		$display("done single pulse stop");
	endtask

	task automatic t_cap();
		wr(tsp_pkg::OFF_CMPP, 0);
		wr(tsp_pkg::OFF_FLAG, 32'h0000_0007);
		u_pins.set_b(1, 1'b1);
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_CAP, tsp_pkg::EDGE_RISE,
			tsp_pkg::EDGE_FALL, 1, 1, 1));
		repeat (50) @(posedge clk);
		u_pins.set_a(1'b1);
		repeat (10) @(posedge clk);
		rd(tsp_pkg::OFF_CMPA);
		va = v;
		check("capture a", 32'(va > 52 && va < 66), 1);
		check("no drive", {a_oe, b_oe}, 0);
		u_pins.set_b(1, 1'b0);
		repeat (10) @(posedge clk);
		rd(tsp_pkg::OFF_CMPB);
		check("capture b", 32'(v > va + 8 && v < va + 30), 1);
		rd(tsp_pkg::OFF_FLAG);
		check("capture flags", v, 3);
		wr(tsp_pkg::OFF_FLAG, 32'h0000_0007);
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_CAP, tsp_pkg::EDGE_BOTH,
			tsp_pkg::EDGE_NONE, 1, 1, 0));
		u_pins.set_a(1'b0);
		u_pins.set_b(1, 1'b1);
		repeat (120) @(posedge clk);
		rd(tsp_pkg::OFF_FLAG);
		check("both and none edges", v, 1);
		rd(tsp_pkg::OFF_CNT);
		check("full range count", 32'(v > 200 && v < 400), 1);
		$display("done capture");
	endtask

	task automatic t_period();
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_CAP, tsp_pkg::EDGE_NONE,
			tsp_pkg::EDGE_NONE, 1, 0, 0));
		wr(tsp_pkg::OFF_CMPP, 1);
		wr(tsp_pkg::OFF_FLAG, 32'h0000_0007);
		wr(tsp_pkg::OFF_CTRL, ctl(tsp_pkg::MODE_CAP, tsp_pkg::EDGE_NONE,
			tsp_pkg::EDGE_NONE, 1, 1, 0));
		repeat (300) @(posedge clk);
		rd(tsp_pkg::OFF_FLAG);
		check("period flag", v, 4);
		rd(tsp_pkg::OFF_CNT);
		check("period wrap", 32'(v < 128), 1);
		$display("done period");
	endtask

	// -----------------------------------------------------------------
	// run control
	// -----------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		fail_count = 0;
		n_tests = 0;
		a_cnt = 0;
		b_cnt = '{0, 0, 0};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_sp_sw();
		t_sp_trig();
		t_sp_stop();
		t_cap();
		t_period();
		end_of_test();
	end
endmodule
